// ==== snt_pkg.sv ====
package snt_pkg;

    // Field and counter widths
    localparam int FW = 5;
    localparam int GW = 2;
    localparam int DW = 2;
    localparam int NW = 4;
    localparam int TW = 16;

    // System clock 20 ns; functional timing base is twice that, so one
    // system cycle is the half functional cycle used by the extra delays
    localparam int SYS_CLOCK_PERIOD_NS = 20;
    localparam int FUNC_CLOCK_PERIOD_NS = 40;
    localparam logic [TW-1:0] SYS_PER_FUNC =
        TW'(FUNC_CLOCK_PERIOD_NS / SYS_CLOCK_PERIOD_NS);

    localparam int FIFO_DEPTH = 32;
    localparam int REQ_W = 1 + NW;

    // Divider encodings
    localparam logic [DW-1:0] DIV_BY_1 = 2'h0;
    localparam logic [DW-1:0] DIV_BY_2 = 2'h1;
    localparam logic [DW-1:0] DIV_BY_3 = 2'h2;

    localparam int MOD3_BIAS = 3 * (2 ** FW);
    localparam logic [TW-1:0] T_ZERO = 16'h0000;
    localparam logic [TW-1:0] T_ONE = 16'h0001;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b10
    } snt_state_t;

    // Field times (granularity + 1), in functional cycles
    function automatic logic [TW-1:0] scale(input logic [TW-1:0] f,
                                           input logic [GW-1:0] g);
        scale = TW'(f * (TW'(g) + T_ONE));
    endfunction : scale

    // Functional cycles to system cycles
    function automatic logic [TW-1:0] to_sys(input logic [TW-1:0] f);
        to_sys = TW'(f * SYS_PER_FUNC);
    endfunction : to_sys

    // Whole functional cycles that align a strobe to the divided clock
    function automatic logic [TW-1:0] align_extra(
        input logic [DW-1:0] div,
        input logic [FW-1:0] point,
        input logic [FW-1:0] start);
        int d;
        d = int'(point) - int'(start) + MOD3_BIAS;
        align_extra = T_ZERO;
        if (div == DIV_BY_2) begin
            align_extra = TW'(point[0] ^ start[0]);
        end else if (div == DIV_BY_3) begin
            align_extra = TW'(d % 3);
        end
    endfunction : align_extra

endpackage : snt_pkg

// ==== snt_fifo.sv ====
`timescale 1ns/100ps
module snt_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic full_reg, full_next, empty_reg, empty_next;
    logic push, pop;

    always_comb begin
        push = in_valid && !full_reg;
        pop = out_ready && !empty_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
        end
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
        full_next = (cnt_next == CNT_FULL);
        empty_next = (cnt_next == '0);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
            full_reg <= full_next;
            empty_reg <= empty_next;
        end
    end

    // Storage needs no reset; empty flag masks stale words
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = mem[rd_ptr_reg];

endmodule : snt_fifo

// ==== snt_strobe_timing.sv ====
`timescale 1ns/100ps
// Function
// - Single read: chip select low (read release - assert point) scaled.
// - Burst read stretches chip select by (n-1) page intervals, scaled.
// - Burst write chip select low (write release - assert + burst) scaled.
// - First bus clock edge clock_start_delay cycles after address valid.
// - Single read byte enables low read_cycle_length scaled cycles.
// - Burst read releases byte enables and latch after final data edge.
// - Burst write releases byte enables and latch after final edge.
// - Burst write releases chip select relative to final data edge.
// - Divider 0: chip select delayed by half-cycle extra delay only.
// - Divider 1: one more cycle before chip select unless parity matches.
// - Divider 2: zero to two more cycles by difference modulo three.
// - Divider 1: one more cycle before address latch unless parity matches.
// - Single access: address latch low (release point - assert point) scaled cycles.
// - Bus clock rate follows the clock divide ratio setting.
module snt_strobe_timing (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Access requests
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [snt_pkg::NW-1:0] req_burst_len,
    // Timing configuration
    input wire logic [snt_pkg::FW-1:0] cs_assert_point,
    input wire logic [snt_pkg::FW-1:0] cs_read_release,
    input wire logic [snt_pkg::FW-1:0] cs_write_release,
    input wire logic [snt_pkg::GW-1:0] granularity_factor,
    input wire logic [snt_pkg::FW-1:0] burst_page_interval,
    input wire logic [snt_pkg::FW-1:0] clock_start_delay,
    input wire logic [snt_pkg::FW-1:0] read_cycle_length,
    input wire logic [snt_pkg::FW-1:0] write_cycle_length,
    input wire logic [snt_pkg::FW-1:0] data_valid_cycles,
    input wire logic [snt_pkg::DW-1:0] clock_divide_ratio,
    input wire logic cs_half_cycle_delay,
    input wire logic [snt_pkg::FW-1:0] addr_latch_assert_point,
    input wire logic addr_latch_half_cycle_delay,
    input wire logic [snt_pkg::FW-1:0] addr_latch_release_point,
    input wire logic [snt_pkg::FW-1:0] addr_latch_wr_release,
    // Memory strobes
    output logic bus_clk,
    output logic cs_n,
    output logic addr_latch_n,
    output logic lo_byte_en_cmd_latch,
    output logic hi_byte_en_n,
    // Status
    output logic busy,
    output logic access_done
);
    localparam int TW = snt_pkg::TW;
    localparam int FW = snt_pkg::FW;

    logic fifo_ready, fifo_valid, pop;
    logic [snt_pkg::REQ_W-1:0] fifo_data;

    snt_fifo #(
        .WIDTH(snt_pkg::REQ_W),
        .DEPTH(snt_pkg::FIFO_DEPTH)
    ) u_req_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(fifo_ready),
        .in_data({req_write, req_burst_len}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );
    assign req_ready = fifo_ready;

    // Configuration snapshot, held for the whole access
    snt_pkg::snt_state_t state_reg, state_next;
    logic wr_reg, wr_next;
    logic [snt_pkg::NW-1:0] n_reg, n_next;
    logic [FW-1:0] c_cs_on, c_cs_rd, c_cs_wr, c_burst, c_clk, c_rd, c_wr;
    logic [FW-1:0] c_acc, c_adv_on, c_adv_rd, c_adv_wr;
    logic [snt_pkg::GW-1:0] c_g;
    logic [snt_pkg::DW-1:0] c_div;
    logic c_cs_half, c_adv_half;

    assign pop = fifo_valid && (state_reg == snt_pkg::ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {c_cs_on, c_cs_rd, c_cs_wr, c_burst, c_clk} <= '0;
            {c_rd, c_wr, c_acc, c_adv_on, c_adv_rd, c_adv_wr} <= '0;
            c_g <= '0;
            c_div <= '0;
            c_cs_half <= 1'b0;
            c_adv_half <= 1'b0;
        end else if (pop) begin
            c_cs_on <= cs_assert_point;
            c_cs_rd <= cs_read_release;
            c_cs_wr <= cs_write_release;
            c_burst <= burst_page_interval;
            c_clk <= clock_start_delay;
            c_rd <= read_cycle_length;
            c_wr <= write_cycle_length;
            c_acc <= data_valid_cycles;
            c_adv_on <= addr_latch_assert_point;
            c_adv_rd <= addr_latch_release_point;
            c_adv_wr <= addr_latch_wr_release;
            c_g <= granularity_factor;
            c_div <= clock_divide_ratio;
            c_cs_half <= cs_half_cycle_delay;
            c_adv_half <= addr_latch_half_cycle_delay;
        end
    end

    // Event times in system cycles from address valid
    logic [TW-1:0] nm1, fe, cyc, cs_rel, adv_rel, x_cs, x_adv, h_cs, h_adv;
    logic [TW-1:0] cs_on_t, cs_off_t, adv_on_t, adv_off_t, be_off_t;
    logic [TW-1:0] clk_on_t, end_t, clk_hi, clk_last;
    logic burst;

    always_comb begin
        nm1 = (n_reg == '0) ? snt_pkg::T_ZERO : TW'(n_reg) - snt_pkg::T_ONE;
        burst = (nm1 != snt_pkg::T_ZERO);
        cyc = wr_reg ? TW'(c_wr) : TW'(c_rd);
        cs_rel = wr_reg ? TW'(c_cs_wr) : TW'(c_cs_rd);
        adv_rel = wr_reg ? TW'(c_adv_wr) : TW'(c_adv_rd);
        // Final data edge; chip select and byte enable releases count from it, address latch release only in a burst
        fe = snt_pkg::scale(TW'(TW'(c_acc) + TW'(nm1 * TW'(c_burst))), c_g);
        x_cs = snt_pkg::align_extra(c_div, c_cs_on, c_clk);
        x_adv = snt_pkg::align_extra(c_div, c_adv_on, c_clk);
        h_cs = TW'(c_cs_half);
        h_adv = TW'(c_adv_half);
        cs_on_t = TW'(snt_pkg::to_sys(TW'(snt_pkg::scale(TW'(c_cs_on), c_g)
                  + x_cs)) + h_cs);
        // Same shift on both edges keeps the width exact
        cs_off_t = TW'(snt_pkg::to_sys(TW'(fe + snt_pkg::scale(
                   TW'(cs_rel - TW'(c_acc)), c_g) + x_cs)) + h_cs);
        be_off_t = snt_pkg::to_sys(TW'(fe + snt_pkg::scale(
                   TW'(cyc - TW'(c_acc)), c_g)));
        adv_on_t = TW'(snt_pkg::to_sys(TW'(snt_pkg::scale(TW'(c_adv_on), c_g)
                   + x_adv)) + h_adv);
        if (burst) begin
            adv_off_t = TW'(snt_pkg::to_sys(TW'(fe + snt_pkg::scale(
                        TW'(cyc - TW'(c_acc)), c_g) + x_adv)) + h_adv);
        end else begin
            adv_off_t = TW'(snt_pkg::to_sys(TW'(snt_pkg::scale(adv_rel, c_g)
                        + x_adv)) + h_adv);
        end
        clk_on_t = snt_pkg::to_sys(TW'(c_clk));
        clk_hi = TW'(TW'(c_div) + snt_pkg::T_ONE);
        clk_last = TW'(snt_pkg::to_sys(clk_hi) - snt_pkg::T_ONE);
        end_t = cs_off_t;
        if (adv_off_t > end_t) begin
            end_t = adv_off_t;
        end
        if (be_off_t > end_t) begin
            end_t = be_off_t;
        end
    end

    // Sequencer and strobes
    logic [TW-1:0] t_reg, t_next, ph_reg, ph_next;
    logic clk_next, cs_n_next, adv_n_next, be_n_next, busy_next, done_next;

    always_comb begin
        state_next = state_reg;
        wr_next = wr_reg;
        n_next = n_reg;
        t_next = t_reg;
        ph_next = snt_pkg::T_ZERO;
        clk_next = 1'b0;
        cs_n_next = 1'b1;
        adv_n_next = 1'b1;
        be_n_next = 1'b1;
        busy_next = 1'b0;
        done_next = 1'b0;
        unique case (state_reg)
            snt_pkg::ST_IDLE: begin
                t_next = snt_pkg::T_ZERO;
                if (pop) begin
                    wr_next = fifo_data[snt_pkg::REQ_W-1];
                    n_next = fifo_data[snt_pkg::NW-1:0];
                    state_next = snt_pkg::ST_RUN;
                end
            end
            snt_pkg::ST_RUN: begin
                busy_next = 1'b1;
                cs_n_next = !(t_reg >= cs_on_t && t_reg < cs_off_t);
                adv_n_next = !(t_reg >= adv_on_t && t_reg < adv_off_t);
                be_n_next = !(t_reg < be_off_t);
                // Phase restarts at the first edge, aligned to clk_sys
                if (t_reg >= clk_on_t && ph_reg != clk_last) begin
                    ph_next = TW'(ph_reg + snt_pkg::T_ONE);
                end
                clk_next = (t_reg >= clk_on_t) && (t_reg < end_t)
                           && (ph_reg < clk_hi);
                t_next = TW'(t_reg + snt_pkg::T_ONE);
                if (t_reg >= end_t) begin
                    state_next = snt_pkg::ST_DONE;
                end
            end
            snt_pkg::ST_DONE: begin
                done_next = 1'b1;
                state_next = snt_pkg::ST_IDLE;
            end
            default: begin
                state_next = snt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= snt_pkg::ST_IDLE;
            wr_reg <= 1'b0;
            n_reg <= '0;
            t_reg <= '0;
            ph_reg <= '0;
            bus_clk <= 1'b0;
            cs_n <= 1'b1;
            addr_latch_n <= 1'b1;
            lo_byte_en_cmd_latch <= 1'b1;
            hi_byte_en_n <= 1'b1;
            busy <= 1'b0;
            access_done <= 1'b0;
        end else begin
            state_reg <= state_next;
            wr_reg <= wr_next;
            n_reg <= n_next;
            t_reg <= t_next;
            ph_reg <= ph_next;
            bus_clk <= clk_next;
            cs_n <= cs_n_next;
            addr_latch_n <= adv_n_next;
            lo_byte_en_cmd_latch <= be_n_next;
            hi_byte_en_n <= be_n_next;
            busy <= busy_next;
            access_done <= done_next;
        end
    end

    // Low-time counters and bus clock high-time counter, read only by the checks below
    logic [TW-1:0] cs_lo, be_lo, adv_lo, ck_hi_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_lo <= '0;
            be_lo <= '0;
            adv_lo <= '0;
            ck_hi_cnt <= '0;
        end else begin
            cs_lo <= cs_n ? snt_pkg::T_ZERO : TW'(cs_lo + snt_pkg::T_ONE);
            be_lo <= lo_byte_en_cmd_latch ? snt_pkg::T_ZERO
                     : TW'(be_lo + snt_pkg::T_ONE);
            adv_lo <= addr_latch_n ? snt_pkg::T_ZERO
                      : TW'(adv_lo + snt_pkg::T_ONE);
            ck_hi_cnt <= bus_clk ? TW'(ck_hi_cnt + snt_pkg::T_ONE)
                         : snt_pkg::T_ZERO;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_cs_read_width: assert property ($rose(cs_n) && !wr_reg |->
        cs_lo == snt_pkg::to_sys(snt_pkg::scale(TW'(TW'(c_cs_rd)
        - TW'(c_cs_on) + TW'(nm1 * TW'(c_burst))), c_g)))
        else $error("chip select read width wrong");
    a_cs_write_width: assert property ($rose(cs_n) && wr_reg |->
        cs_lo == snt_pkg::to_sys(snt_pkg::scale(TW'(TW'(c_cs_wr)
        - TW'(c_cs_on) + TW'(nm1 * TW'(c_burst))), c_g)))
        else $error("chip select write width wrong");
    a_be_single_read: assert property ($rose(lo_byte_en_cmd_latch)
        && !wr_reg && !burst |->
        be_lo == snt_pkg::to_sys(snt_pkg::scale(TW'(c_rd), c_g)))
        else $error("byte enable single read width wrong");
    a_clk_first_edge: assert property ($fell(lo_byte_en_cmd_latch) |->
        bus_clk == (snt_pkg::to_sys(TW'(c_clk)) == snt_pkg::T_ZERO))
        else $error("bus clock started early");
    a_clk_start_time: assert property ($past(state_reg) == snt_pkg::ST_RUN
        && $past(t_reg) == snt_pkg::to_sys(TW'(c_clk))
        && $past(t_reg) < $past(end_t) |-> $rose(bus_clk))
        else $error("first bus clock edge misplaced");
    a_cs_align_div0: assert property ($fell(cs_n) && c_div ==
        snt_pkg::DIV_BY_1 |-> $past(t_reg) == TW'(snt_pkg::to_sys(
        snt_pkg::scale(TW'(c_cs_on), c_g)) + TW'(c_cs_half)))
        else $error("chip select half delay wrong");
    a_cs_align_div1: assert property ($fell(cs_n) && c_div ==
        snt_pkg::DIV_BY_2 |-> $past(t_reg) == TW'(snt_pkg::to_sys(TW'(
        snt_pkg::scale(TW'(c_cs_on), c_g) + TW'(c_cs_on[0] ^ c_clk[0])))
        + TW'(c_cs_half)))
        else $error("chip select parity alignment wrong");
    a_cs_align_div2: assert property ($fell(cs_n) && c_div ==
        snt_pkg::DIV_BY_3 |-> $past(t_reg) - TW'(c_cs_half)
        - snt_pkg::to_sys(snt_pkg::scale(TW'(c_cs_on), c_g))
        <= snt_pkg::to_sys(TW'(2)))
        else $error("chip select modulo alignment too long");
    a_adv_align_div1: assert property ($fell(addr_latch_n) && c_div ==
        snt_pkg::DIV_BY_2 |-> $past(t_reg) == TW'(snt_pkg::to_sys(TW'(
        snt_pkg::scale(TW'(c_adv_on), c_g) + TW'(c_adv_on[0] ^ c_clk[0])))
        + TW'(c_adv_half)))
        else $error("address latch parity alignment wrong");
    a_adv_width: assert property ($rose(addr_latch_n) && !burst |->
        adv_lo == snt_pkg::to_sys(snt_pkg::scale(TW'(adv_rel
        - TW'(c_adv_on)), c_g)))
        else $error("address latch width wrong");
    a_burst_release: assert property ($rose(lo_byte_en_cmd_latch) && burst
        |-> $past(t_reg) == snt_pkg::to_sys(TW'(fe + snt_pkg::scale(
        TW'(cyc - TW'(c_acc)), c_g))) ##0 ($rose(addr_latch_n)
        || c_adv_half || x_adv != snt_pkg::T_ZERO))
        else $error("burst release misplaced");
    a_bus_clk_high: assert property ($fell(bus_clk) && $past(t_reg) <
        end_t |-> ck_hi_cnt == clk_hi)
        else $error("bus clock high time wrong");

    c_single_read: cover property ($rose(cs_n) && !wr_reg && !burst);
    c_burst_write: cover property ($rose(cs_n) && wr_reg && burst);
    c_div3_access: cover property (access_done && c_div == snt_pkg::DIV_BY_3);
    c_fifo_full: cover property (!req_ready ##1 req_ready);

endmodule : snt_strobe_timing

// ==== snt_flash_model.sv ====
`timescale 1ns/100ps
module snt_flash_model (
    // Sampling clock
    input wire logic clk_sys,
    // Controller strobes
    input wire logic bus_clk,
    input wire logic cs_n,
    input wire logic addr_latch_n,
    input wire logic lo_byte_en_cmd_latch,
    input wire logic hi_byte_en_n,
    // Widths and delays in clk_sys cycles
    output logic [15:0] cs_w,
    output logic [15:0] be_w,
    output logic [15:0] adv_w,
    output logic [15:0] cs_at,
    output logic [15:0] adv_at,
    output logic [15:0] clk_at,
    output logic [15:0] ck_hi,
    output logic [15:0] be_diff
);
    logic [15:0] t = 0, cs_c = 0, be_c = 0, adv_c = 0, ck_c = 0;
    logic cs_d = 1, adv_d = 1, ck_d = 0, ck_seen = 0, hi_seen = 0;
    // Listener only: read data would come back on a bus not modelled here
    initial be_diff = 0;
    always @(posedge clk_sys) begin
        t <= lo_byte_en_cmd_latch ? 16'h0000 : t + 16'h0001;
        cs_d <= cs_n;
        adv_d <= addr_latch_n;
        ck_d <= bus_clk;
        if (!cs_n) begin
            cs_c <= cs_c + 16'h0001;
        end else if (cs_c != 0) begin
            cs_w <= cs_c;
            cs_c <= 16'h0000;
        end
        if (!lo_byte_en_cmd_latch) begin
            be_c <= be_c + 16'h0001;
        end else if (be_c != 0) begin
            be_w <= be_c;
            be_c <= 16'h0000;
        end
        if (!addr_latch_n) begin
            adv_c <= adv_c + 16'h0001;
        end else if (adv_c != 0) begin
            adv_w <= adv_c;
            adv_c <= 16'h0000;
        end
        if (cs_d && !cs_n) begin
            cs_at <= t;
        end
        if (adv_d && !addr_latch_n) begin
            adv_at <= t;
        end
        if (bus_clk && !ck_d && !ck_seen) begin
            clk_at <= t;
            ck_seen <= 1'h1;
        end
        // Only the first pulse: the last one may be cut by the forced low
        if (bus_clk) begin
            ck_c <= ck_c + 16'h0001;
        end else if (ck_c != 0) begin
            if (!hi_seen) begin
                ck_hi <= ck_c;
            end
            hi_seen <= 1'h1;
            ck_c <= 16'h0000;
        end
        if (lo_byte_en_cmd_latch) begin
            ck_seen <= 1'h0;
            hi_seen <= 1'h0;
        end
        if (lo_byte_en_cmd_latch !== hi_byte_en_n) begin
            be_diff <= be_diff + 16'h0001;
        end
    end
endmodule : snt_flash_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic clk_sys, rst, req_valid, req_ready, req_write, hc, ha;
    logic [snt_pkg::NW-1:0] req_burst_len;
    logic [snt_pkg::GW-1:0] gran;
    logic [snt_pkg::DW-1:0] div;
    logic [snt_pkg::FW-1:0] con, crd, cwr, bpi, cst, rc, wc, ac, aon, ard, awr;
    logic bus_clk, cs_n, adv_n, be_lo, be_hi, busy, access_done;
    logic [15:0] cs_w, be_w, adv_w, cs_at, adv_at, clk_at, ck_hi, be_diff;
    int num_errors = 0;
    int check_count = 0;
    int done_cnt = 0;

    snt_strobe_timing DUT (
        .clk_sys, .rst, .req_valid, .req_ready, .req_write, .req_burst_len,
        .cs_assert_point(con), .cs_read_release(crd),
        .cs_write_release(cwr), .granularity_factor(gran),
        .burst_page_interval(bpi), .clock_start_delay(cst),
        .read_cycle_length(rc), .write_cycle_length(wc),
        .data_valid_cycles(ac), .clock_divide_ratio(div),
        .cs_half_cycle_delay(hc), .addr_latch_assert_point(aon),
        .addr_latch_half_cycle_delay(ha), .addr_latch_release_point(ard),
        .addr_latch_wr_release(awr), .bus_clk, .cs_n, .addr_latch_n(adv_n),
        .lo_byte_en_cmd_latch(be_lo), .hi_byte_en_n(be_hi), .busy,
        .access_done
    );

    snt_flash_model mem (
        .clk_sys, .bus_clk, .cs_n, .addr_latch_n(adv_n),
        .lo_byte_en_cmd_latch(be_lo), .hi_byte_en_n(be_hi),
        .cs_w, .be_w, .adv_w, .cs_at, .adv_at, .clk_at, .ck_hi, .be_diff
    );

    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (access_done === 1'h1) begin
            done_cnt <= done_cnt + 1;
        end
    end

    task automatic stop_test;
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk

    task automatic hang(input string what);
        num_errors++;
        $display("[ERR] %s expected done seen timeout", what);
        stop_test();
    endtask : hang

    function automatic int xf(input int d, input int p, input int s);
        if (d == 1) begin
            return (p + s) % 2;
        end
        if (d == 2) begin
            return (p - s + 96) % 3;
        end
        return 0;
    endfunction : xf

    // Settings only change while idle; the pop takes its own snapshot
    task automatic cfg(input int g, d, c_on, c_rd, c_wr, st, yr, yw, a,
                       a_on, a_rd, h);
        @(posedge clk_sys);
        gran <= g[1:0];
        div <= d[1:0];
        con <= c_on[4:0];
        crd <= c_rd[4:0];
        cwr <= c_wr[4:0];
        cst <= st[4:0];
        rc <= yr[4:0];
        wc <= yw[4:0];
        ac <= a[4:0];
        aon <= a_on[4:0];
        ard <= a_rd[4:0];
        awr <= a_rd[4:0];
        hc <= h[0];
        ha <= h[0];
    endtask : cfg

    task automatic run(input logic w, input int n);
        int i;
        logic seen;
        seen = 1'h0;
        @(posedge clk_sys);
        req_valid <= 1'h1;
        req_write <= w;
        req_burst_len <= n[3:0];
        @(posedge clk_sys);
        req_valid <= 1'h0;
        for (i = 0; i < 2000 && access_done !== 1'h1; i++) begin
            @(posedge clk_sys);
            if (busy === 1'h1) begin
                seen = 1'h1;
            end
        end
        if (access_done !== 1'h1) begin
            hang("access_done");
        end
        chk("busy_seen", 16'h0001, 16'(seen));
        chk("busy_end", 16'h0000, 16'(busy));
        repeat (4) @(posedge clk_sys);
    endtask : run

    task automatic sc_single(input int g);
        int s;
        cfg(g, 0, 1, 5, 5, 3, 8, 8, 4, 1, 4, 0);
        run(1'h0, 1);
        s = g + 1;
        chk("cs_w", 16'(2 * (crd - con) * s), cs_w);
        chk("be_w", 16'(2 * rc * s), be_w);
        chk("adv_w", 16'(2 * (ard - aon) * s), adv_w);
        chk("clk_at", 16'(2 * cst), clk_at);
        chk("ck_hi", 16'h0001, ck_hi);
        chk("be_diff", 16'h0000, be_diff);
    endtask : sc_single

    task automatic sc_burst(input logic w, input int n);
        int e, cy, rel;
        cfg(1, 0, 1, 6, 5, 2, 7, 6, 4, 1, 3, 0);
        run(w, n);
        cy = w ? wc : rc;
        rel = w ? cwr : crd;
        e = 2 * (rel - con + (n - 1) * bpi) * 2;
        chk("cs_w", 16'(e), cs_w);
        e = 2 * (cy + (n - 1) * bpi) * 2;
        chk("be_w", 16'(e), be_w);
        chk("adv_w", 16'(e - 4 * aon), adv_w);
    endtask : sc_burst

    task automatic sc_align(input int d, c_on, a_on, st, h);
        cfg(0, d, c_on, 12, 12, st, 14, 14, 5, a_on, 10, h);
        run(1'h0, 1);
        chk("cs_at", 16'(2 * (c_on + xf(d, c_on, st)) + h), cs_at);
        chk("adv_at", 16'(2 * (a_on + xf(d, a_on, st)) + h), adv_at);
        chk("ck_hi", 16'(d + 1), ck_hi);
        chk("clk_at", 16'(2 * st), clk_at);
    endtask : sc_align

    // Requests beyond a full queue must be dropped, not queued late
    task automatic sc_fifo;
        int i, n, d0;
        logic full;
        cfg(0, 0, 0, 2, 2, 0, 3, 3, 1, 0, 1, 0);
        d0 = done_cnt;
        n = 0;
        full = 1'h0;
        req_write <= 1'h1;
        req_burst_len <= 4'h1;
        req_valid <= 1'h1;
        for (i = 0; i < 64 && !full; i++) begin
            @(posedge clk_sys);
            if (req_ready === 1'h1) begin
                n++;
            end else begin
                full = 1'h1;
            end
        end
        req_valid <= 1'h0;
        if (!full) begin
            hang("fill");
        end
        chk("filled", 16'h0001, 16'(n >= snt_pkg::FIFO_DEPTH));
        for (i = 0; i < 5000 && done_cnt - d0 < n; i++) begin
            @(posedge clk_sys);
        end
        if (done_cnt - d0 != n) begin
            hang("drain");
        end
        chk("ready", 16'h0001, 16'(req_ready));
    endtask : sc_fifo

    initial begin
        rst = 1'h1;
        req_valid = 1'h0;
        req_write = 1'h0;
        req_burst_len = 4'h1;
        {gran, div, hc, ha, con, crd, cwr, cst, rc, wc, ac, aon, ard} = '0;
        awr = 5'h00;
        bpi = 5'h02;
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        chk("idle", 16'h003D,
            16'({bus_clk, cs_n, adv_n, be_lo, be_hi, busy, req_ready}));
        sc_single(0);
        sc_single(2);
        sc_burst(1'h0, 4);
        sc_burst(1'h1, 3);
        sc_align(0, 2, 1, 1, 1);
        sc_align(1, 2, 3, 1, 0);
        sc_align(1, 3, 2, 1, 1);
        sc_align(2, 3, 1, 1, 0);
        sc_align(2, 2, 4, 1, 1);
        sc_align(2, 0, 2, 1, 0);
        sc_fifo();
        stop_test();
    end
endmodule : testbench
